/* rtl/bridge_ctrl_pkg.sv */
/*
  Constants, state encodings and carrier structs for the brushed motor bridge
  control block. Assumes a 250 MHz core clock.
*/
package bridge_ctrl_pkg;

  // ----------------------------------------------------------------------
  // clock and times
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STANDBY_NOM_NS = 1000000;
  localparam int STANDBY_CYC = STANDBY_NOM_NS * 1000 / CLK_PERIOD_PS;
  localparam int WAKE_MAX_NS = 30000;
  localparam int WAKE_CYC = WAKE_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int BLANK_NS = 3600;
  localparam int BLANK_CYC = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int TRIP_BLANK_NS = 400;
  localparam int TRIP_BLANK_CYC = (TRIP_BLANK_NS * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
  localparam int DEAD_NS = 200;
  localparam int DEAD_CYC = (DEAD_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int OFF_TIME_CYC_DEFAULT = 5000;
  localparam int FAULT_RECOVER_CYC_DEFAULT = 250000;

  // ----------------------------------------------------------------------
  // widths, trip scaling (reference / 10)
  // ----------------------------------------------------------------------
  localparam int CNT_W = 20;
  localparam int ADC_W = 12;
  localparam int TRIP_DIV = 10;
  localparam int TRIP_LAT_W = 2;

  typedef logic [CNT_W-1:0] count_t;
  typedef logic [ADC_W-1:0] sample_t;

  typedef enum logic [2:0] {
    PH_OFF    = 3'b000,
    PH_CHARGE = 3'b001,
    PH_FAST   = 3'b010,
    PH_SLOW   = 3'b011,
    PH_BRAKE  = 3'b100,
    PH_STBY   = 3'b101,
    PH_WAKE   = 3'b110
  } phase_e;

  typedef struct packed {
    logic upperA;
    logic upperB;
    logic lowerA;
    logic lowerB;
  } gates_s;

  localparam gates_s GATES_OFF = '{default: 1'b0};

endpackage

/* rtl/trip_filter.sv */
/*
  Trip filter: holds a sensed-current trip for a minimum run of cycles before
  reporting it. Assumes samples synchronous to core_clk.
*/
`timescale 1ns/10ps
module trip_filter
  import bridge_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire sample_t senseLevel,
  input wire sample_t tripLevel,
  output logic tripOut
);

  typedef struct packed {
    logic [7:0] cnt;
    logic trip;
  } filt_s;

  filt_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.trip = 1'b0;
    if (!enable || senseLevel < tripLevel) begin
      s_d.cnt = 8'h00;
    end else if (s_q.cnt < 8'(TRIP_BLANK_CYC)) begin
      s_d.cnt = s_q.cnt + 8'h01; // RQ8
    end else begin
      s_d.trip = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tripOut = s_q.trip;

endmodule

/* rtl/brushed_motor_bridge_control.sv */
/*
  Control logic for one full bridge driving a brushed DC motor: input decode,
  standby timer, constant-current chopping with mixed decay, blanking and
  dead time, fault shutdown. Assumes synchronous inputs and digitised sense.
*/
// Function
// RQ1: a high b low forward, reverse mirrors, both high brake, both low off.
// RQ2: both inputs low for the standby delay enters standby.
// RQ3: controller keeps stop intervals at or below minimum standby delay.
// RQ4: controller holds both low at least maximum delay for standby.
// RQ5: controller does not change inputs inside the standby transition window.
// RQ6: input high in standby wakes; outputs follow within wake-up time. Code settles WAKE_CYCLES (default the max); outputs follow 2 cycles later.
// RQ7: trip comparison ignored for blank time after decay to charge.
// RQ8: short blanking near the trip level avoids false trips.
// RQ9: every control input change also starts the spike blank time.
// RQ10: after trip, fixed off time, half fast decay then half slow.
// RQ11: zero current during fast decay turns all switches off.
// RQ12: forward: charge upper a lower b, fast upper b lower a, slow lowers.
// RQ13: reverse current mirrors the switch assignment between a and b.
// RQ14: dead time with switches off at every output switching event.
// RQ15: charge ends when sense reaches reference divided by ten.
// RQ16: any fault turns all switches off; resumes after clear or recovery. Code waits for the clear, then the recovery time.
// RQ17: controller keeps input toggle rate at or below the maximum.
// RQ18: standby timer restarts whenever either input is high.
`timescale 1ns/10ps
module brushed_motor_bridge_control
  import bridge_ctrl_pkg::*;
#(
  parameter int STANDBY_CYCLES = STANDBY_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int OFF_TIME_CYCLES = OFF_TIME_CYC_DEFAULT,
  parameter int FAULT_RECOVER_CYCLES = FAULT_RECOVER_CYC_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ctrl_input_a,
  input wire logic ctrl_input_b,
  input wire sample_t current_sense_node,
  input wire sample_t referenceLevel,
  input wire logic zeroCurrent,
  input wire logic overcurrent_detect,
  input wire logic thermal_shutdown_detect,
  input wire logic underVoltage,
  output gates_s bridgeGates,
  output logic bridge_out_a,
  output logic bridge_out_b,
  output logic bridgeOutEnA,
  output logic bridgeOutEnB,
  output logic standbyActive,
  output logic faultActive
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic gates_s phaseGates(phase_e ph, logic rev);
    gates_s g;
    g = GATES_OFF;
    case (ph)
      PH_CHARGE: begin
        g.upperA = !rev; // RQ12
        g.lowerB = !rev;
        g.upperB = rev; // RQ13
        g.lowerA = rev;
      end
      PH_FAST: begin
        g.upperB = !rev; // RQ12
        g.lowerA = !rev;
        g.upperA = rev; // RQ13
        g.lowerB = rev;
      end
      PH_SLOW, PH_BRAKE: begin
        g.lowerA = 1'b1; // RQ12
        g.lowerB = 1'b1;
      end
      default: g = GATES_OFF;
    endcase
    return g;
  endfunction

  function automatic logic conflict(gates_s a, gates_s b);
    return (a != b) && (a != GATES_OFF);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    phase_e phase;
    logic rev;
    logic [1:0] inPrev;
    count_t idleCnt;
    count_t phaseCnt;
    count_t blankCnt;
    count_t deadCnt;
    count_t faultCnt;
    logic fault;
    gates_s gates;
    logic outA;
    logic outB;
    logic enA;
    logic enB;
    logic stby;
    logic hiz;
  } ctrl_s;

  ctrl_s s_q, s_d;
  sample_t tripLevel;
  logic tripSeen;
  logic faultIn;
  logic [1:0] inNow;
  gates_s want;

  // reference scaled down by the attenuation ratio
  assign tripLevel = sample_t'(referenceLevel / sample_t'(TRIP_DIV)); // RQ15
  assign faultIn = overcurrent_detect | thermal_shutdown_detect
                   | underVoltage;
  assign inNow = {ctrl_input_a, ctrl_input_b};

  trip_filter u_trip (
    .core_clk(core_clk),
    .rst(rst),
    .enable(s_q.phase == PH_CHARGE && s_q.blankCnt == '0), // RQ7
    .senseLevel(current_sense_node),
    .tripLevel(tripLevel),
    .tripOut(tripSeen)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.inPrev = inNow;
    want = GATES_OFF;
    if (s_q.blankCnt != '0) begin
      s_d.blankCnt = s_q.blankCnt - count_t'(1);
    end
    if (inNow != s_q.inPrev) begin
      s_d.blankCnt = count_t'(BLANK_CYC); // RQ9
    end
    // standby timer restarts on any high input
    if (inNow != 2'b00) begin
      s_d.idleCnt = '0; // RQ18
    end else if (s_q.idleCnt < count_t'(STANDBY_CYCLES)) begin
      s_d.idleCnt = s_q.idleCnt + count_t'(1);
    end
    // fault: latch, hold off until clear and recovery time done
    if (faultIn) begin
      s_d.fault = 1'b1; // RQ16
      s_d.faultCnt = '0;
    end else if (s_q.fault) begin
      if (s_q.faultCnt >= count_t'(FAULT_RECOVER_CYCLES)) begin
        s_d.fault = 1'b0; // RQ16
      end else begin
        s_d.faultCnt = s_q.faultCnt + count_t'(1);
      end
    end
    if (s_q.phase != PH_CHARGE && s_q.phase != PH_FAST
        && s_q.phase != PH_SLOW) begin
      s_d.phaseCnt = '0;
    end
    case (s_q.phase)
      PH_STBY: begin
        if (inNow != 2'b00) begin
          s_d.phase = PH_WAKE; // RQ6
          s_d.phaseCnt = '0;
        end
      end
      PH_WAKE: begin
        // wake-up is a fixed settle, equal by default to the max
        if (s_q.phaseCnt >= count_t'(WAKE_CYCLES - 1)) begin
          s_d.phase = PH_OFF; // RQ6
        end else begin
          s_d.phaseCnt = s_q.phaseCnt + count_t'(1);
        end
      end
      PH_FAST: begin
        if (zeroCurrent) begin
          s_d.hiz = 1'b1; // RQ11
        end
        if (s_q.phaseCnt >= count_t'(OFF_TIME_CYCLES / 2 - 1)) begin
          s_d.phase = PH_SLOW; // RQ10
        end
        s_d.phaseCnt = s_q.phaseCnt + count_t'(1);
      end
      PH_SLOW: begin
        if (s_q.phaseCnt >= count_t'(OFF_TIME_CYCLES - 1)) begin
          s_d.phase = PH_CHARGE; // RQ10
          s_d.blankCnt = count_t'(BLANK_CYC); // RQ7
          s_d.phaseCnt = '0;
        end else begin
          s_d.phaseCnt = s_q.phaseCnt + count_t'(1);
        end
      end
      default: begin
        // an input change outranks a trip seen in the same cycle
        if (s_q.phase == PH_CHARGE && tripSeen && inNow == s_q.inPrev) begin
          s_d.phase = PH_FAST; // RQ10
          s_d.phaseCnt = '0;
        end else begin
          case (inNow)
            2'b10: begin
              s_d.rev = 1'b0;
              if (s_q.phase != PH_CHARGE || s_q.rev) begin
                s_d.phase = PH_CHARGE; // RQ1
              end
            end
            2'b01: begin
              s_d.rev = 1'b1;
              if (s_q.phase != PH_CHARGE || !s_q.rev) begin
                s_d.phase = PH_CHARGE; // RQ1
              end
            end
            2'b11: s_d.phase = PH_BRAKE; // RQ1
            default: begin
              s_d.phase = PH_OFF; // RQ1
              if (s_q.idleCnt >= count_t'(STANDBY_CYCLES - 1)) begin
                s_d.phase = PH_STBY; // RQ2
              end
            end
          endcase
        end
      end
    endcase
    // decay phases follow the inputs too, so direct pwm can stop chopping
    if ((s_q.phase == PH_FAST || s_q.phase == PH_SLOW)
        && inNow != s_q.inPrev) begin
      s_d.phase = PH_OFF;
    end
    if (s_d.fault) begin
      s_d.phase = PH_OFF; // RQ16
    end
    s_d.stby = (s_d.phase == PH_STBY || s_d.phase == PH_WAKE);
    // zero current keeps the bridge off for the rest of the off time,
    // so charging never restarts without the decay to charge blanking
    if (s_d.phase != PH_FAST && s_d.phase != PH_SLOW) begin
      s_d.hiz = 1'b0;
    end
    // gate drive with dead time between differing patterns
    want = s_d.hiz ? GATES_OFF : phaseGates(s_d.phase, s_d.rev); // RQ11
    if (s_q.deadCnt != '0) begin
      s_d.deadCnt = s_q.deadCnt - count_t'(1);
      s_d.gates = GATES_OFF; // RQ14
    end else if (conflict(s_q.gates, want)) begin
      s_d.gates = GATES_OFF; // RQ14
      s_d.deadCnt = count_t'(DEAD_CYC - 1);
    end else begin
      s_d.gates = want;
    end
    if (s_d.fault) begin
      s_d.gates = GATES_OFF; // RQ16
    end
    s_d.outA = s_d.gates.upperA;
    s_d.outB = s_d.gates.upperB;
    s_d.enA = s_d.gates.upperA | s_d.gates.lowerA;
    s_d.enB = s_d.gates.upperB | s_d.gates.lowerB;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bridgeGates = s_q.gates;
  assign bridge_out_a = s_q.outA;
  assign bridge_out_b = s_q.outB;
  assign bridgeOutEnA = s_q.enA;
  assign bridgeOutEnB = s_q.enB;
  assign standbyActive = s_q.stby;
  assign faultActive = s_q.fault;

endmodule

/* testbench/host_model.sv */
/* host model: turns a requested mode into the two control inputs.
   assumes the bench paces stop and standby intervals */
`timescale 1ns/10ps
module host_model (
  input wire logic core_clk,
  input wire logic [1:0] mode,
  output logic ctrl_input_a = 1'b0,
  output logic ctrl_input_b = 1'b0
);
  // ----
  // drive
  // ----
  // at most one change per clock, far under the toggle limit
  always @(posedge core_clk) begin
    ctrl_input_a <= mode[1];
    ctrl_input_b <= mode[0];
  end
endmodule

/* testbench/bridge_ctrl_monitor.sv */
/* port checker for the bridge control block.
   assumes it is bound to the top module */
`timescale 1ns/10ps
module bridge_ctrl_monitor
  import bridge_ctrl_pkg::*;
#(
  parameter int STANDBY_CYCLES = 200,
  parameter int WAKE_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ctrl_input_a,
  input wire logic ctrl_input_b,
  input wire sample_t current_sense_node,
  input wire sample_t referenceLevel,
  input wire logic zeroCurrent,
  input wire logic overcurrent_detect,
  input wire logic thermal_shutdown_detect,
  input wire logic underVoltage,
  input wire gates_s bridgeGates,
  input wire logic bridge_out_a,
  input wire logic bridge_out_b,
  input wire logic bridgeOutEnA,
  input wire logic bridgeOutEnB,
  input wire logic standbyActive,
  input wire logic faultActive
);
  // ----
  // helpers
  // ----
  localparam int WAKE_LIM = WAKE_CYCLES + 4;
  logic [9:0] stab;
  logic [9:0] quiet;
  logic [1:0] inPrev;
  wire fwd = ctrl_input_a && !ctrl_input_b;
  wire low = !ctrl_input_a && !ctrl_input_b;
  wire flt = overcurrent_detect || thermal_shutdown_detect || underVoltage;
  wire [3:0] g = bridgeGates;
  wire hot = current_sense_node >= referenceLevel / TRIP_DIV;
  wire moved = {ctrl_input_a, ctrl_input_b} != inPrev;
  wire noisy = moved || hot || flt || faultActive || zeroCurrent;
  // counters read through a gate so a change is seen in its own cycle
  wire [9:0] age = moved ? 10'h000 : stab;
  wire [9:0] calm = noisy ? 10'h000 : quiet;
  always_ff @(posedge core_clk) begin
    inPrev <= {ctrl_input_a, ctrl_input_b};
    stab <= rst ? 10'h000 : age + 10'(age != 10'h3FF);
    quiet <= rst ? 10'h000 : calm + 10'(calm != 10'h3FF);
  end
  // ----
  // properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_fast_left;
    fwd && age > 10'h384 && !zeroCurrent && !faultActive
      && $fell(g == 4'h6);
  endsequence
  sequence s_slow_next;
    ##[0:60] g == 4'h3;
  endsequence
  a_fault_off:
    assert property (flt |=> g == 4'h0 && faultActive)
    else $error("gates on after fault");
  a_no_shoot:
    assert property (!(g[3] && g[1]) && !(g[2] && g[0]))
    else $error("leg shorted");
  a_stop_hiz:
    assert property (low && age >= 10'h002 |-> !bridgeOutEnA && !bridgeOutEnB)
    else $error("stop drives");
  a_blank_hold:
    assert property (fwd && !faultActive && age inside {[10'h046:10'h352]}
      |-> g == 4'h9)
    else $error("trip inside blank");
  a_fwd_charge:
    assert property (fwd && calm >= 10'h258
      |-> g == 4'h9 && bridge_out_a && !bridge_out_b)
    else $error("no charge");
  a_standby_in:
    assert property (low && age >= STANDBY_CYCLES + 4 |-> standbyActive)
    else $error("no standby");
  a_wake_bound:
    assert property (standbyActive && !low |-> ##[1:WAKE_LIM] !standbyActive)
    else $error("slow wake");
  a_decay_order:
    assert property (s_fast_left |-> s_slow_next)
    else $error("no slow after fast");
  a_zero_hiz:
    assert property (fwd && age > 10'h384 && g == 4'h6 && zeroCurrent
      |-> ##[1:2] g == 4'h0)
    else $error("zero current drives");
endmodule

bind brushed_motor_bridge_control bridge_ctrl_monitor #(
  .STANDBY_CYCLES(STANDBY_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)
) mon (
  .core_clk, .rst, .ctrl_input_a, .ctrl_input_b, .current_sense_node,
  .referenceLevel, .zeroCurrent, .overcurrent_detect,
  .thermal_shutdown_detect, .underVoltage, .bridgeGates, .bridge_out_a,
  .bridge_out_b, .bridgeOutEnA, .bridgeOutEnB, .standbyActive, .faultActive
);

/* testbench/brushed_motor_bridge_control_tb.sv */
/* bench for the bridge control block with a host model.
   assumes shortened counts set at the instance */
`timescale 1ns/10ps
module brushed_motor_bridge_control_tb;
  import bridge_ctrl_pkg::*;
  // ----
  // setup
  // ----
  localparam int FR = 50;
  localparam sample_t TRIP = sample_t'(12'h3E8 / TRIP_DIV);
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic ctrl_input_a, ctrl_input_b;
  sample_t current_sense_node = 12'h000;
  sample_t referenceLevel = 12'h3E8;
  logic zeroCurrent = 1'b0;
  logic [2:0] flt = 3'h0;
  gates_s bridgeGates;
  logic bridge_out_a, bridge_out_b, bridgeOutEnA, bridgeOutEnB;
  logic standbyActive, faultActive;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  always #2 core_clk = ~core_clk;
  host_model host (.core_clk, .mode, .ctrl_input_a, .ctrl_input_b);
  brushed_motor_bridge_control #(.STANDBY_CYCLES(200), .WAKE_CYCLES(10),
    .OFF_TIME_CYCLES(400), .FAULT_RECOVER_CYCLES(FR)) uut (
    .core_clk, .rst, .ctrl_input_a, .ctrl_input_b, .current_sense_node,
    .referenceLevel, .zeroCurrent, .overcurrent_detect(flt[0]),
    .thermal_shutdown_detect(flt[1]), .underVoltage(flt[2]), .bridgeGates,
    .bridge_out_a, .bridge_out_b, .bridgeOutEnA, .bridgeOutEnB,
    .standbyActive, .faultActive);
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // n counts edges until the pattern shows, or while it stays
  task waitg(input logic [3:0] e, input int lim);
    n = 0;
    while (bridgeGates !== e && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task holdg(input logic [3:0] e);
    n = 0;
    while (bridgeGates === e && n < 1000) begin
      cyc(1);
      n++;
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_modes;
    logic [1:0] m [4];
    logic [3:0] e [4];
    logic [3:0] o [4];
    m = '{2'h2, 2'h1, 2'h3, 2'h0};
    e = '{4'h9, 4'h6, 4'h3, 4'h0};
    o = '{4'hB, 4'h7, 4'h3, 4'h0};
    for (int i = 0; i < 4; i++) begin
      mode <= m[i];
      cyc(10);
      if (i inside {[1:2]}) chk(bridgeGates === GATES_OFF, "dead");
      cyc(90);
      chk(bridgeGates === e[i], "gates");
      chk({bridge_out_a, bridge_out_b, bridgeOutEnA, bridgeOutEnB} === o[i],
        "pins");
    end
  endtask
  task t_trip;
    mode <= 2'h2;
    cyc(10);
    current_sense_node <= TRIP;
    cyc(800);
    chk(bridgeGates === 4'h9, "unblanked");
    current_sense_node <= 12'h000;
    cyc(300);
    current_sense_node <= TRIP;
    cyc(50);
    current_sense_node <= TRIP - 12'h001;
    cyc(400);
    chk(bridgeGates === 4'h9, "false trip");
    current_sense_node <= TRIP;
    waitg(4'h6, 300);
    chk(n < 300, "no trip");
    current_sense_node <= 12'h000;
    holdg(4'h6);
    chk(n inside {[140:210]}, "fast len");
    waitg(4'h3, 70);
    chk(n < 70, "no slow");
    holdg(4'h3);
    chk(n inside {[140:210]}, "slow len");
    waitg(4'h9, 70);
    chk(n < 70, "no charge");
  endtask
  task t_zero;
    current_sense_node <= TRIP;
    waitg(4'h6, 1200);
    zeroCurrent <= 1'b1;
    cyc(3);
    chk(bridgeGates === GATES_OFF && bridgeOutEnA === 1'b0, "zero");
    zeroCurrent <= 1'b0;
    current_sense_node <= 12'h000;
    cyc(100);
    chk(bridgeGates === GATES_OFF, "zero held");
    cyc(1400);
    chk(bridgeGates === 4'h9, "zero resume");
  endtask
  task t_fault;
    for (int i = 0; i < 3; i++) begin
      flt <= 3'h1 << i;
      cyc(3);
      chk(bridgeGates === GATES_OFF && faultActive === 1'b1, "fault");
      flt <= 3'h0;
      cyc(FR - 10);
      chk(faultActive === 1'b1, "early");
      cyc(30);
      chk(faultActive === 1'b0, "stuck");
      cyc(1000);
      chk(bridgeGates === 4'h9, "resume");
    end
  endtask
  task t_standby;
    mode <= 2'h0;
    cyc(100);
    mode <= 2'h2;
    cyc(5);
    mode <= 2'h0;
    cyc(130);
    chk(standbyActive === 1'b0, "restart");
    cyc(170);
    chk(standbyActive === 1'b1 && bridgeOutEnA === 1'b0, "standby");
    mode <= 2'h1;
    cyc(30);
    chk(standbyActive === 1'b0 && bridgeGates === 4'h6, "wake");
  endtask
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    t_modes();
    t_trip();
    t_zero();
    t_fault();
    t_standby();
    report_and_stop();
  end
  // about three times the expected run
  initial begin
    #120000;
    mismatches++;
    report_and_stop();
  end
endmodule
